//--- rtl/afcl_cfg.svh
`ifndef AFCL_CFG_SVH
`define AFCL_CFG_SVH
// widths
`define AFCL_DISC_W 12
`define AFCL_ACC_W 24
`define AFCL_OFS_W 10
`define AFCL_FRAC_W 22
`define AFCL_RSSI_W 10
`define AFCL_LVL_W 12
// frequency scale: hz per readout step, and pll units per step
`define AFCL_HZ_PER_STEP 2680
`define AFCL_PLL_PER_STEP 8
// rssi correction: slope is unsigned q4.4, offset signed
`define AFCL_SLOPE_ONE 8'h0010
// threshold defaults in 0.1 db steps
`define AFCL_THR_BASE_DEF 12'h027F
`define AFCL_THR_LOW_DEF 12'h0080
`define AFCL_THR_HIGH_DEF 12'h0100
`define AFCL_HYS_DEF 12'h00D5
// adc sample rate and system clock
`define AFCL_ADC_RATE_HZ 274000
`define AFCL_SYS_CLK_HZ 100000000
`define AFCL_ADC_DIV (`AFCL_SYS_CLK_HZ / `AFCL_ADC_RATE_HZ)
`define AFCL_DIV_W 9
`define AFCL_TIME_W 16
`endif

//--- rtl/afcl_loops.sv
// What this block does
// - frequency error is dc level of parallel demod path without pre lowpass
// - estimate acquired during preamble, then held for rest of datagram
// - frequency loop is always active, off, or timed around signal identification
// - timed loop starts at identification, or freezes one window after it; correction held afterwards
// - in ask the frequency loop updates only while ask data is high
// - frequency offset is clamped to a programmable magnitude limit
// - bandwidth set by first gain, damping by second gain
// - loop output readable signed at 2.68 khz per step, clamped
// - first if buffer attenuation set by a 4 bit manual code
// - gain loop selects one of three second if gain steps
// - rssi corrected by programmable offset and slope before gain control
// - corrected rssi enters peak memory integrator with attack and decay coeffs
// - integrator output feeds two hysteretic comparators, low and high
// - one hysteresis value sets release threshold of both comparators
// - comparator states drive analog gain and digital gain correction
// - integrator difference signal indexes the delog table
// - thresholds are in db above a programmable base, with defaults
// - gain returns to maximum hysteresis below the lower threshold
// - peak memory integrator runs at the 274 khz adc rate
// - gain loop start and freeze timing set in its own fields
// - pll modulator word is 22 bits with lsb forced high
// - frequency unit turns demod offset into divider correction
`timescale 1ns/10ps
`default_nettype none
`include "afcl_cfg.svh"
module afcl_loops
   import afcl_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   // demodulator side
   input wire logic signed [`AFCL_DISC_W-1:0] afc_disc_in,
   input wire logic disc_valid_in,
   input wire logic ask_mode_in,
   input wire logic ask_data_pin_in,
   input wire logic sig_ident_in,
   input wire logic [`AFCL_RSSI_W-1:0] rssi_raw_in,
   // frequency loop configuration
   input wire logic [3:0] freq_loop_bw_gain_in,
   input wire logic [3:0] freq_loop_damp_gain_in,
   input wire logic [`AFCL_OFS_W-2:0] freq_offset_clamp_in,
   input wire afcl_timing_t afc_timing_in,
   input wire logic [`AFCL_FRAC_W-1:0] pll_frac_nominal_in,
   // gain loop configuration
   input wire logic [3:0] if_attenuation_code_in,
   input wire logic signed [7:0] rssi_offset_corr_in,
   input wire logic [7:0] rssi_slope_corr_in,
   input wire logic [3:0] attack_coeff_in,
   input wire logic [3:0] decay_coeff_in,
   input wire afcl_thresh_t gain_thresh_in,
   input wire logic [`AFCL_LVL_W-1:0] digital_gain_corr_in,
   input wire afcl_timing_t agc_timing_in,
   // outputs
   output logic signed [`AFCL_OFS_W-1:0] freq_offset_readout_out,
   output logic [`AFCL_FRAC_W-1:0] pll_frac_out,
   output logic [3:0] first_if_buffer_out,
   output logic [1:0] if_gain_step_out,
   output logic [`AFCL_LVL_W-1:0] rssi_digital_out,
   output logic signed [`AFCL_LVL_W:0] delog_index_out,
   output logic afc_active_out,
   output logic agc_active_out
);
   // pin synchronisers for data and identification event
   logic [1:0] ask_sync_r;
   logic [1:0] sid_sync_r;
   logic sid_prev_r;
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ask_sync_r <= 2'h0;
         sid_sync_r <= 2'h0;
         sid_prev_r <= 1'b0;
      end else begin
         ask_sync_r <= {ask_sync_r[0], ask_data_pin_in};
         sid_sync_r <= {sid_sync_r[0], sig_ident_in};
         sid_prev_r <= sid_sync_r[1];
      end
   end
   wire logic sid_pulse = sid_sync_r[1] & ~sid_prev_r;
   wire logic ask_high = ask_sync_r[1];

   // activity window timers, one per loop
   logic [`AFCL_TIME_W-1:0] afc_cnt_r;
   logic afc_run_r;
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         afc_cnt_r <= '0;
         afc_run_r <= 1'b0;
      end else if (sid_pulse) begin
         afc_cnt_r <= afc_timing_in.window;
         afc_run_r <= (afc_timing_in.mode == AFCL_START_AT_SID);
      end else if (afc_cnt_r != '0) begin
         afc_cnt_r <= afc_cnt_r - 1'b1;
      end else begin
         afc_run_r <= 1'b0;
      end
   end
   logic [`AFCL_TIME_W-1:0] agc_cnt_r;
   logic agc_run_r;
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         agc_cnt_r <= '0;
         agc_run_r <= 1'b0;
      end else if (sid_pulse) begin
         agc_cnt_r <= agc_timing_in.window;
         agc_run_r <= (agc_timing_in.mode == AFCL_START_AT_SID);
      end else if (agc_cnt_r != '0) begin
         agc_cnt_r <= agc_cnt_r - 1'b1;
      end else begin
         agc_run_r <= 1'b0;
      end
   end
   // freeze mode: active until identification, then for window more cycles
   logic afc_frz_done_r;
   logic agc_frz_done_r;
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         afc_frz_done_r <= 1'b0;
         agc_frz_done_r <= 1'b0;
      end else begin
         if (sid_pulse) begin
            afc_frz_done_r <= 1'b1;
            agc_frz_done_r <= 1'b1;
         end
      end
   end
   // activity decode
   always_comb begin
      unique case (afc_timing_in.mode)
         AFCL_ALWAYS: afc_active_out = 1'b1;
         AFCL_START_AT_SID: afc_active_out = afc_run_r;
         AFCL_FREEZE_AT_SID: afc_active_out = !afc_frz_done_r || (afc_cnt_r != '0);
         AFCL_OFF: afc_active_out = 1'b0;
      endcase
      unique case (agc_timing_in.mode)
         AFCL_ALWAYS: agc_active_out = 1'b1;
         AFCL_START_AT_SID: agc_active_out = agc_run_r;
         AFCL_FREEZE_AT_SID: agc_active_out = !agc_frz_done_r || (agc_cnt_r != '0);
         AFCL_OFF: agc_active_out = 1'b0;
      endcase
   end

   // frequency loop filter: integrator then pi stage
   logic signed [`AFCL_ACC_W-1:0] int1_r;
   logic signed [`AFCL_ACC_W-1:0] int2_r;
   logic signed [`AFCL_ACC_W-1:0] int1_nxt;
   logic signed [`AFCL_ACC_W-1:0] int2_nxt;
   logic signed [`AFCL_ACC_W-1:0] pi_sum;
   logic signed [`AFCL_ACC_W-1:0] lim;
   wire logic afc_upd = afc_active_out && disc_valid_in && (!ask_mode_in || ask_high);
   always_comb begin
      lim = `AFCL_ACC_W'(freq_offset_clamp_in) <<< 8;
      // first gain integrates the demod dc error
      int1_nxt = int1_r + (`AFCL_ACC_W'(afc_disc_in) >>> freq_loop_bw_gain_in);
      // bound the first integrator so a lasting error cannot wrap it
      if (int1_nxt > lim) begin
         int1_nxt = lim;
      end else if (int1_nxt < -lim) begin
         int1_nxt = -lim;
      end
      // second gain forms the integral branch of the pi stage
      int2_nxt = int2_r + (int1_nxt >>> freq_loop_damp_gain_in);
      if (int2_nxt > lim) begin
         int2_nxt = lim;
      end else if (int2_nxt < -lim) begin
         int2_nxt = -lim;
      end
      pi_sum = int2_nxt + int1_nxt;
      if (pi_sum > lim) begin
         pi_sum = lim;
      end else if (pi_sum < -lim) begin
         pi_sum = -lim;
      end
   end
   logic signed [`AFCL_ACC_W-1:0] out_acc_r;
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         int1_r <= '0;
         int2_r <= '0;
         out_acc_r <= '0;
      end else if (afc_upd) begin
         int1_r <= int1_nxt;
         int2_r <= int2_nxt;
         out_acc_r <= pi_sum; // held when inactive
      end
   end
   // readout and pll word
   logic signed [`AFCL_FRAC_W-1:0] frac_sum;
   always_comb begin
      frac_sum = $signed(pll_frac_nominal_in)
         + `AFCL_FRAC_W'($signed(out_acc_r[`AFCL_ACC_W-1:8]) * `AFCL_PLL_PER_STEP);
   end
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         freq_offset_readout_out <= '0;
         pll_frac_out <= `AFCL_FRAC_W'(1);
      end else begin
         freq_offset_readout_out <= out_acc_r[`AFCL_OFS_W+7:8];
         pll_frac_out <= {frac_sum[`AFCL_FRAC_W-1:1], 1'b1};
      end
   end

   // first if buffer manual code
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         first_if_buffer_out <= 4'h0;
      end else begin
         first_if_buffer_out <= if_attenuation_code_in;
      end
   end

   // adc rate strobe
   logic [`AFCL_DIV_W-1:0] adc_div_r;
   wire logic adc_tick = (adc_div_r == `AFCL_DIV_W'(`AFCL_ADC_DIV - 1));
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         adc_div_r <= '0;
      end else begin
         adc_div_r <= adc_tick ? '0 : adc_div_r + 1'b1;
      end
   end

   // rssi correction: offset then slope, plus digital gain correction
   logic [1:0] cmp_r;
   logic signed [`AFCL_LVL_W+9:0] corr;
   logic [`AFCL_LVL_W-1:0] rssi_corr;
   always_comb begin
      corr = (($signed({1'b0, rssi_raw_in}) + rssi_offset_corr_in)
         * $signed({1'b0, rssi_slope_corr_in})) >>> 4;
      if (cmp_r != 2'h0) begin
         corr = corr + $signed({1'b0, digital_gain_corr_in});
      end
      if (corr < 0) begin
         rssi_corr = '0;
      end else if (corr > $signed({1'b0, {`AFCL_LVL_W{1'b1}}})) begin
         rssi_corr = '1;
      end else begin
         rssi_corr = corr[`AFCL_LVL_W-1:0];
      end
   end

   // peak memory integrator
   logic [`AFCL_LVL_W+7:0] pmi_r;
   logic signed [`AFCL_LVL_W:0] diff;
   logic [3:0] shift;
   always_comb begin
      diff = $signed({1'b0, rssi_corr}) - $signed({1'b0, pmi_r[`AFCL_LVL_W+7:8]});
      shift = (diff > 0) ? attack_coeff_in : 4'(attack_coeff_in + decay_coeff_in);
   end
   logic signed [`AFCL_LVL_W+8:0] step;
   always_comb begin
      step = ($signed({diff, 8'h00})) >>> shift;
   end
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pmi_r <= '0;
         delog_index_out <= '0;
         rssi_digital_out <= '0;
      end else if (adc_tick) begin
         pmi_r <= (`AFCL_LVL_W+8)'($signed({1'b0, pmi_r}) + step);
         delog_index_out <= diff;
         rssi_digital_out <= rssi_corr;
      end
   end

   // hysteretic comparators in db above base
   logic [`AFCL_LVL_W+1:0] t_lo;
   logic [`AFCL_LVL_W+1:0] t_hi;
   logic [`AFCL_LVL_W+1:0] lvl;
   always_comb begin
      lvl = {2'b00, pmi_r[`AFCL_LVL_W+7:8]};
      t_lo = {2'b00, gain_thresh_in.base} + {2'b00, gain_thresh_in.low};
      t_hi = {2'b00, gain_thresh_in.base} + {2'b00, gain_thresh_in.high};
   end
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cmp_r <= 2'h0;
      end else if (adc_tick && agc_active_out) begin
         if (lvl >= t_lo) begin
            cmp_r[0] <= 1'b1;
         end else if (lvl + {2'b00, gain_thresh_in.hys} < t_lo) begin
            cmp_r[0] <= 1'b0;
         end
         if (lvl >= t_hi) begin
            cmp_r[1] <= 1'b1;
         end else if (lvl + {2'b00, gain_thresh_in.hys} < t_hi) begin
            cmp_r[1] <= 1'b0;
         end
      end
   end
   // three gain steps: 0 max, 1 reduced, 2 minimum
   always_comb begin
      if_gain_step_out = cmp_r[1] ? 2'h2 : (cmp_r[0] ? 2'h1 : 2'h0);
   end

   // checks
   AST_HOLD_INACTIVE: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      !afc_active_out |=> $stable(freq_offset_readout_out) || $past(afc_upd, 2))
      else $error("offset moved while loop inactive");
   AST_ASK_LOW_HOLD: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      ask_mode_in && !ask_high |=> $stable(out_acc_r))
      else $error("loop updated during ask low");
   AST_CLAMP: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      afc_upd |=> (out_acc_r <= $past(lim)) && (out_acc_r >= -$past(lim)))
      else $error("offset exceeds clamp");
   AST_LSB_HIGH: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      ##1 pll_frac_out[0])
      else $error("pll word lsb low");
   AST_ATT_CODE: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      arst_n_in |=> first_if_buffer_out == $past(if_attenuation_code_in))
      else $error("attenuation code not applied");
   AST_GAIN_STEP: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      if_gain_step_out != 2'h3)
      else $error("illegal gain step");
   AST_PMI_RATE: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      !adc_tick |=> $stable(pmi_r))
      else $error("integrator moved off adc tick");
   AST_RELEASE: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      adc_tick && agc_active_out && (lvl + {2'b00, gain_thresh_in.hys} < t_lo) |=> cmp_r[0] == 1'b0)
      else $error("gain not released below hysteresis");
   // start option: identification opens the window on the next cycle
   sequence seq_sid_start;
      sid_pulse && (afc_timing_in.mode == AFCL_START_AT_SID);
   endsequence
   AST_START_WINDOW: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      seq_sid_start |=> afc_active_out)
      else $error("loop not started at identification");
   // freeze option: once the window is spent the correction stays put
   sequence seq_frz_spent;
      (afc_timing_in.mode == AFCL_FREEZE_AT_SID) && afc_frz_done_r && (afc_cnt_r == '0);
   endsequence
   AST_FREEZE_HOLD: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      seq_frz_spent |=> $stable(out_acc_r))
      else $error("correction moved after freeze window");
   // delog index is the integrator difference taken at the adc tick
   AST_DELOG_IDX: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      adc_tick |=> delog_index_out == $past(diff))
      else $error("delog index not the integrator difference");
endmodule
`default_nettype wire

//--- rtl/afcl_pkg.sv
package afcl_pkg;
   // loop activity option
   typedef enum logic [1:0] {
      AFCL_ALWAYS,
      AFCL_START_AT_SID,
      AFCL_FREEZE_AT_SID,
      AFCL_OFF
   } afcl_mode_t;
   // timing of one loop
   typedef struct packed {
      afcl_mode_t mode;
      logic [15:0] window;
   } afcl_timing_t;
   // gain loop thresholds
   typedef struct packed {
      logic [11:0] base;
      logic [11:0] low;
      logic [11:0] high;
      logic [11:0] hys;
   } afcl_thresh_t;
endpackage

//--- test/afcl_demod_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "afcl_cfg.svh"
module afcl_demod_model (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // what the far side presents
   input wire logic signed [`AFCL_DISC_W-1:0] err_in,
   input wire logic [3:0] gap_in,
   input wire logic ask_hi_in,
   input wire logic ident_in,
   input wire logic [`AFCL_RSSI_W-1:0] lvl_in,
   // demodulator and rssi outputs
   output logic signed [`AFCL_DISC_W-1:0] disc_out,
   output logic valid_out,
   output logic ask_out,
   output logic ident_out,
   output logic [`AFCL_RSSI_W-1:0] rssi_out
);
   logic [3:0] gap_r;
   // dc level once every gap_in+1 clocks, toggling junk in between
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         gap_r <= 4'h0;
         valid_out <= 1'b0;
         disc_out <= '0;
         ask_out <= 1'b0;
         ident_out <= 1'b0;
         rssi_out <= '0;
      end else begin
         gap_r <= (gap_r >= gap_in) ? 4'h0 : gap_r + 4'h1;
         valid_out <= (gap_r >= gap_in);
         disc_out <= (gap_r >= gap_in) ? err_in : ~disc_out;
         ask_out <= ask_hi_in;
         ident_out <= ident_in;
         rssi_out <= lvl_in;
      end
   end
endmodule
`default_nettype wire

//--- test/afcl_loops_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "afcl_cfg.svh"
module afcl_loops_tb
   import afcl_pkg::*;
;
   typedef struct packed {
      logic [3:0] kind;
      logic [21:0] exp;
   } afcl_note_t;
   localparam logic [21:0] NOM = 22'h20_0001;
   localparam logic [8:0] CLAMP = 9'h01E;
   // design inputs, model controls, outputs
   logic sys_clk_in, arst_n_in, chk_go, ask_hi, ident;
   logic signed [11:0] afc_disc_in, err;
   logic disc_valid_in, ask_mode_in, ask_data_pin_in, sig_ident_in;
   logic [9:0] rssi_raw_in, lvl;
   logic [3:0] gap, freq_loop_bw_gain_in, freq_loop_damp_gain_in, if_attenuation_code_in;
   logic [3:0] attack_coeff_in, decay_coeff_in, first_if_buffer_out;
   logic [8:0] freq_offset_clamp_in;
   afcl_timing_t afc_timing_in, agc_timing_in;
   logic [21:0] pll_frac_nominal_in, pll_frac_out;
   logic signed [7:0] rssi_offset_corr_in;
   logic [7:0] rssi_slope_corr_in;
   afcl_thresh_t gain_thresh_in;
   logic [11:0] digital_gain_corr_in, rssi_digital_out;
   logic signed [9:0] freq_offset_readout_out;
   logic signed [12:0] delog_index_out;
   logic [1:0] if_gain_step_out;
   logic afc_active_out, agc_active_out;
   afcl_note_t notes[$];
   int miscompares, num_checks;
   logic [31:0] rnd;
   afcl_loops uut (
      .sys_clk_in, .arst_n_in, .afc_disc_in, .disc_valid_in, .ask_mode_in, .ask_data_pin_in,
      .sig_ident_in, .rssi_raw_in, .freq_loop_bw_gain_in, .freq_loop_damp_gain_in,
      .freq_offset_clamp_in, .afc_timing_in, .pll_frac_nominal_in, .if_attenuation_code_in,
      .rssi_offset_corr_in, .rssi_slope_corr_in, .attack_coeff_in, .decay_coeff_in,
      .gain_thresh_in, .digital_gain_corr_in, .agc_timing_in, .freq_offset_readout_out,
      .pll_frac_out, .first_if_buffer_out, .if_gain_step_out, .rssi_digital_out,
      .delog_index_out, .afc_active_out, .agc_active_out
   );
   afcl_demod_model far_end (
      .clk_in(sys_clk_in), .rst_n_in(arst_n_in), .err_in(err), .gap_in(gap),
      .ask_hi_in(ask_hi), .ident_in(ident), .lvl_in(lvl), .disc_out(afc_disc_in),
      .valid_out(disc_valid_in), .ask_out(ask_data_pin_in), .ident_out(sig_ident_in),
      .rssi_out(rssi_raw_in)
   );
   // 100 mhz clock
   initial begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return x[0] ? ((x >> 1) ^ 32'h8020_0003) : (x >> 1);
   endfunction
   task automatic clk_n(input int n);
      repeat (n) @(posedge sys_clk_in);
   endtask
   // note an expected value and flag the monitor
   task automatic chk(input logic [3:0] kind, input logic [21:0] exp);
      notes.push_back('{kind, exp});
      chk_go <= 1'b1;
      clk_n(1);
      chk_go <= 1'b0;
      clk_n(1);
   endtask
   task automatic do_reset();
      arst_n_in <= 1'b0;
      clk_n(3);
      arst_n_in <= 1'b1;
      clk_n(2);
   endtask
   task automatic end_sim();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // take the oldest note and compare it with the output it names
   always @(posedge sys_clk_in) begin
      afcl_note_t n;
      logic [21:0] got, d;
      if (chk_go) begin
         n = notes.pop_front();
         d = pll_frac_out - NOM;
         case (n.kind)
            4'h0: got = freq_offset_readout_out[9] ? 22'(-freq_offset_readout_out) :
               22'(freq_offset_readout_out);
            4'h1: got = d[21] ? -d : d;
            4'h2: got = 22'(first_if_buffer_out);
            4'h3: got = 22'(if_gain_step_out);
            4'h4: got = 22'(rssi_digital_out);
            4'h5: got = 22'(afc_active_out);
            4'h6: got = 22'(pll_frac_out[0]);
            4'h8: got = 22'(delog_index_out);
            default: got = 22'(agc_active_out);
         endcase
         num_checks++;
         if (got !== n.exp) begin
            miscompares++;
            $display("[FAIL] t=%0t kind %0d got %0h exp %0h", $time, n.kind, got, n.exp);
         end
      end
   end
   // watchdog
   initial begin
      clk_n(90000);
      miscompares++;
      end_sim();
   end
   // main sequence
   initial begin
      int v, tl, th, dg;
      int lv[4];
      int st[4];
      arst_n_in = 1'b0;
      chk_go = 1'b0;
      miscompares = 0;
      num_checks = 0;
      rnd = 32'h0001_8112;
      err = 12'h7FF;
      gap = 4'h3;
      ask_hi = 1'b0;
      ident = 1'b0;
      lvl = 10'h3FF;
      ask_mode_in = 1'b0;
      freq_loop_bw_gain_in = 4'h2;
      freq_loop_damp_gain_in = 4'h2;
      freq_offset_clamp_in = CLAMP;
      afc_timing_in = '{mode: AFCL_OFF, window: 16'h0190};
      agc_timing_in = '{mode: AFCL_OFF, window: 16'h0190};
      pll_frac_nominal_in = NOM;
      if_attenuation_code_in = 4'h0;
      rssi_offset_corr_in = 8'h00;
      rssi_slope_corr_in = 8'h10;
      attack_coeff_in = 4'h0;
      decay_coeff_in = 4'h1;
      gain_thresh_in = '{`AFCL_THR_BASE_DEF, `AFCL_THR_LOW_DEF, `AFCL_THR_HIGH_DEF, `AFCL_HYS_DEF};
      digital_gain_corr_in = 12'h000;
      clk_n(10);
      arst_n_in <= 1'b1;
      clk_n(300);
      // both loops off: nothing moves
      chk(4'h0, 22'h00_0000);
      chk(4'h5, 22'h00_0000);
      chk(4'h6, 22'h00_0001);
      chk(4'h3, 22'h00_0000);
      chk(4'h7, 22'h00_0000);
      for (int i = 0; i < 16; i++) begin
         if_attenuation_code_in <= 4'(i);
         clk_n(2);
         chk(4'h2, 22'(i));
      end
      // always on, then negative error with a slow partner
      afc_timing_in <= '{mode: AFCL_ALWAYS, window: 16'h0190};
      clk_n(600);
      chk(4'h5, 22'h00_0001);
      chk(4'h0, 22'(CLAMP));
      chk(4'h1, 22'(CLAMP) << 3);
      do_reset();
      err <= 12'h800;
      gap <= 4'hA;
      clk_n(1500);
      chk(4'h0, 22'(CLAMP));
      chk(4'h1, 22'(CLAMP) << 3);
      chk(4'h6, 22'h00_0001);
      // ask: updates only while data high
      do_reset();
      ask_mode_in <= 1'b1;
      err <= 12'h7FF;
      gap <= 4'h3;
      clk_n(600);
      chk(4'h0, 22'h00_0000);
      ask_hi <= 1'b1;
      clk_n(600);
      chk(4'h0, 22'(CLAMP));
      // start at identification, then hold
      do_reset();
      ask_mode_in <= 1'b0;
      afc_timing_in <= '{mode: AFCL_START_AT_SID, window: 16'h0190};
      clk_n(300);
      chk(4'h5, 22'h00_0000);
      chk(4'h0, 22'h00_0000);
      ident <= 1'b1;
      clk_n(10);
      chk(4'h5, 22'h00_0001);
      clk_n(450);
      chk(4'h5, 22'h00_0000);
      err <= 12'h800;
      clk_n(600);
      chk(4'h0, 22'(CLAMP));
      chk(4'h1, 22'(CLAMP) << 3);
      // freeze at identification
      ident <= 1'b0;
      err <= 12'h7FF;
      do_reset();
      afc_timing_in <= '{mode: AFCL_FREEZE_AT_SID, window: 16'h0190};
      clk_n(600);
      chk(4'h5, 22'h00_0001);
      ident <= 1'b1;
      clk_n(450);
      chk(4'h5, 22'h00_0000);
      err <= 12'h800;
      clk_n(600);
      chk(4'h0, 22'(CLAMP));
      // rssi correction with random rising levels
      do_reset();
      agc_timing_in <= '{mode: AFCL_ALWAYS, window: 16'h0190};
      rssi_slope_corr_in <= 8'h20;
      for (int k = 0; k < 3; k++) begin
         rnd = lfsr(rnd);
         v = 32 + 100 * k + int'(rnd[5:0]);
         lvl <= 10'(v);
         rssi_offset_corr_in <= {{3{rnd[12]}}, rnd[12:8]};
         v = v + int'($signed(rnd[12:8]));
         clk_n(2912);
         chk(4'h4, 22'(2 * v));
         chk(4'h8, 22'h00_0000);
      end
      chk(4'h7, 22'h00_0001);
      // gain steps around the default thresholds
      rssi_offset_corr_in <= 8'h00;
      rssi_slope_corr_in <= 8'h10;
      tl = `AFCL_THR_BASE_DEF + `AFCL_THR_LOW_DEF;
      th = `AFCL_THR_BASE_DEF + `AFCL_THR_HIGH_DEF;
      lv = '{(tl + th) / 2, 1023, th - 20, 0};
      st = '{1, 2, 2, 0};
      for (int i = 0; i < 4; i++) begin
         dg = (i == 0) ? 0 : 155;
         lvl <= 10'(lv[i]);
         digital_gain_corr_in <= 12'(dg);
         clk_n(10920);
         chk(4'h3, 22'(st[i]));
         chk(4'h4, 22'(lv[i] + ((st[i] != 0) ? dg : 0)));
      end
      end_sim();
   end
endmodule
`default_nettype wire
